// file: common/level_pending_cfg.svh
// offsets, field positions, reset values and counts for the level pending block
`ifndef LEVEL_PENDING_CFG_SVH
`define LEVEL_PENDING_CFG_SVH
`define LEVEL_PENDING_FLAGS_OFS   32'h00c5000c
`define NORMAL_LEVEL_ENABLES_OFS  32'h00c50010
`define NORMAL_PENDING_FLAGS_OFS  32'h00c50014
`define PRIORITY_SELECT_BASE_OFS  32'h00c50040
`define PRIORITY_SELECT_LSB       0
`define PRIORITY_SELECT_MSB       4
`define NUM_LEVELS                32
`define NUM_SOURCES               40
`define REG_RESET                 32'h00000000
`define PLS_RESET                 5'h00
`define HTRANS_NONSEQ_BIT         1
`endif

// file: common/level_pending_pkg.sv
// types shared by the level pending register block
package level_pending_pkg;
  // one ahb-lite request as seen by the slave
  typedef struct packed
  {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;
  // one ahb-lite answer
  typedef struct packed
  {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;
  // register selected by the data phase
  typedef enum logic [4:0]
  {
    sel_none    = 5'h01,
    sel_level   = 5'h02,
    sel_enable  = 5'h04,
    sel_npend   = 5'h08,
    sel_prio    = 5'h10
  } reg_sel_t;
endpackage

// file: logic/level_decoder.sv
// maps sources onto priority levels and ors them into level pending bits
`timescale 1ns/100ps
module level_decoder #(
  parameter int NSRC = 40,                    // interrupt sources
  parameter int NLVL = 32                     // priority levels
) (
  input  wire logic [NSRC-1:0]   src_req,     // current request levels
  input  wire logic [NSRC*5-1:0] src_level,   // priority select per source
  output logic      [NLVL-1:0]   level_bits   // any request per level
);
  // ----------------------------------------------------------------
  // combinational level or
  // ----------------------------------------------------------------
  // pure function of present requests, nothing latched
  always_comb
  begin
    level_bits = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      if (src_req[s])
      begin
        level_bits[src_level[s*5 +: 5]] = 1'b1;
      end
    end
  end
endmodule

// file: logic/level_pending_regs.sv
// ahb-lite register group: level pending, normal enables, normal pending, priority selects
`timescale 1ns/100ps
`include "level_pending_cfg.svh"
module level_pending_regs #(
  parameter int NSRC = `NUM_SOURCES,          // interrupt sources
  parameter int NLVL = `NUM_LEVELS            // priority levels
) (
  input  wire logic                        hclk,        // system clock
  input  wire logic                        hresetn,     // async reset, low
  input  wire level_pending_pkg::ahb_req_t ahb_req,     // bus address phase
  input  wire logic [31:0]                 hwdata,      // bus write data
  output level_pending_pkg::ahb_rsp_t      ahb_rsp,     // bus answer
  input  wire logic [NSRC-1:0]             src_req,     // source requests, same clock
  input  wire logic [NLVL-1:0]             level_mask,  // 1 = level masked off
  output logic      [NLVL-1:0]             level_pending_bits,  // live level pending
  output logic      [NLVL-1:0]             normal_pending_bits, // live normal pending
  output logic                             normal_irq   // normal request to cpu
);
  import level_pending_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [NLVL-1:0]   enables;     // normal enable bits
    logic [NLVL-1:0]   level_q;     // registered level pending
    logic [NLVL-1:0]   npend_q;     // registered normal pending
    logic [NSRC*5-1:0] prio;        // priority select per source
    logic              wr_pend;     // write data phase pending
    reg_sel_t          sel;         // register of data phase
    logic [5:0]        src_idx;     // priority select index
    logic [31:0]       rdata;       // read data
    logic              irq;         // registered cpu request
  } state_t;

  state_t state;                    // registered state
  state_t next_state;               // next value
  logic [NLVL-1:0] level_now;       // combinational level pending

  // decode a word address into a register select
  function automatic reg_sel_t decode(input logic [31:0] a);
    logic [31:0] off;
    off = a - `PRIORITY_SELECT_BASE_OFS;
    if (a == `LEVEL_PENDING_FLAGS_OFS)      decode = sel_level;
    else if (a == `NORMAL_LEVEL_ENABLES_OFS) decode = sel_enable;
    else if (a == `NORMAL_PENDING_FLAGS_OFS) decode = sel_npend;
    else if (a >= `PRIORITY_SELECT_BASE_OFS && (off >> 2) < NSRC) decode = sel_prio;
    else                                     decode = sel_none;
  endfunction

  // ----------------------------------------------------------------
  // source to level mapping
  // ----------------------------------------------------------------
  level_decoder #(
    .NSRC       (NSRC),
    .NLVL       (NLVL)
  ) u_decoder (
    .src_req    (src_req),
    .src_level  (state.prio),
    .level_bits (level_now)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] off;
    logic        take;
    off        = ahb_req.haddr - `PRIORITY_SELECT_BASE_OFS;
    take       = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[`HTRANS_NONSEQ_BIT];
    next_state = state;
    // data phase write lands first
    if (state.wr_pend)
    begin
      case (state.sel)
        sel_enable: next_state.enables = hwdata[NLVL-1:0];
        sel_prio:   next_state.prio[state.src_idx*5 +: 5] = hwdata[`PRIORITY_SELECT_MSB:`PRIORITY_SELECT_LSB];
        sel_level, sel_npend: ;     // read only, dropped quietly
        default: ;                  // unmapped, dropped
      endcase
    end
    // live pending, one cycle behind the request lines
    next_state.level_q = level_now;
    // uses the enable about to be stored so a write takes effect at once
    next_state.npend_q = level_now & next_state.enables;
    next_state.irq     = |(level_now & next_state.enables & ~level_mask);
    // address phase capture
    next_state.wr_pend = 1'b0;
    if (take)
    begin
      next_state.sel     = decode({ahb_req.haddr[31:2], 2'b00});
      next_state.src_idx = 6'((off >> 2));
      next_state.wr_pend = ahb_req.hwrite;
      next_state.rdata   = 32'h00000000;
      if (!ahb_req.hwrite)
      begin
        case (decode({ahb_req.haddr[31:2], 2'b00}))
          sel_level:  next_state.rdata = 32'(state.level_q);
          sel_enable: next_state.rdata = 32'(next_state.enables);
          sel_npend:  next_state.rdata = 32'(state.npend_q);
          sel_prio:   next_state.rdata = 32'(next_state.prio[6'((off >> 2))*5 +: 5]);
          default:    next_state.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset clears every field to a constant
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state         <= '0;
      state.sel     <= sel_none;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states, always okay, even for read-only writes
  assign ahb_rsp.hrdata      = state.rdata;
  assign ahb_rsp.hreadyout   = 1'b1;
  assign ahb_rsp.hresp       = 1'b0;
  assign level_pending_bits  = state.level_q;
  assign normal_pending_bits = state.npend_q;
  assign normal_irq          = state.irq;
endmodule

// file: sim/level_pending_checker.sv
// port assertions for the level pending register block
`timescale 1ns/100ps
`include "level_pending_cfg.svh"
module level_pending_checker #(
  parameter int NSRC = 40,  // sources
  parameter int NLVL = 32   // levels
) (
  input wire logic                        hclk,                 // clock
  input wire logic                        hresetn,              // reset, low
  input wire level_pending_pkg::ahb_req_t ahb_req,              // address phase
  input wire logic [31:0]                 hwdata,               // write data
  input wire level_pending_pkg::ahb_rsp_t ahb_rsp,              // answer
  input wire logic [NSRC-1:0]             src_req,              // requests
  input wire logic [NLVL-1:0]             level_mask,           // masks
  input wire logic [NLVL-1:0]             level_pending_bits,   // level pending
  input wire logic [NLVL-1:0]             normal_pending_bits,  // normal pending
  input wire logic                        normal_irq            // cpu request
);
  import level_pending_pkg::*;
  // a transfer taken at this edge
  wire taken = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_ready_a: assert property (ahb_rsp.hreadyout) else $error("wait state");
  bus_okay_a: assert property (!ahb_rsp.hresp) else $error("error response");
  pend_subset_a: assert property ((normal_pending_bits & ~level_pending_bits) == '0)
    else $error("normal pending without level");
  irq_or_a: assert property (normal_irq == |(normal_pending_bits & ~$past(level_mask)))
    else $error("irq not or of pending");
  level_idle_a: assert property ($past(src_req) == '0 |-> level_pending_bits == '0)
    else $error("level pending without request");
  level_busy_a: assert property ($past(hresetn) && $past(src_req) != '0 |-> level_pending_bits != '0)
    else $error("request lost");
  enable_off_a: assert property (taken && ahb_req.hwrite && ahb_req.haddr == `NORMAL_LEVEL_ENABLES_OFS
    ##1 hwdata == '0 |=> normal_pending_bits == '0) else $error("disabled level pending");
  unmapped_zero_a: assert property (taken && !ahb_req.hwrite && ahb_req.haddr == 32'h00c50020
    |=> ahb_rsp.hrdata == '0) else $error("unmapped read not zero");
endmodule
bind level_pending_regs level_pending_checker #(.NSRC(NSRC), .NLVL(NLVL)) chk (.hclk(hclk), .hresetn(hresetn),
  .ahb_req(ahb_req), .hwdata(hwdata), .ahb_rsp(ahb_rsp), .src_req(src_req), .level_mask(level_mask),
  .level_pending_bits(level_pending_bits), .normal_pending_bits(normal_pending_bits), .normal_irq(normal_irq));

// file: sim/cpu_irq_sink.sv
// cpu side model: counts each new normal request
`timescale 1ns/100ps
module cpu_irq_sink (
  input  wire logic        hclk,        // clock
  input  wire logic        hresetn,     // reset, low
  input  wire logic        normal_irq,  // request in
  output logic      [15:0] irq_entries  // requests taken
);
  logic seen;  // last request level
  // level input: only a rising request is a new entry
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {seen, irq_entries} <= '0;
    else
      {seen, irq_entries} <= {normal_irq, irq_entries + 16'(normal_irq & !seen)};
endmodule

// file: sim/test_level_pending_regs.sv
// self-checking bench for the level pending register block
`timescale 1ns/100ps
`include "level_pending_cfg.svh"
module test_level_pending_regs;
  import level_pending_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq;  // clock, reset, bus
  logic [1:0]  htrans = '0;                                     // transfer kind
  logic [31:0] haddr = '0, hwdata = '0, rd, lvl, en, lp, np;    // bus, model state, pins
  logic [39:0] src_req = '0;                                    // source requests
  logic [31:0] level_mask = '0;                                 // level masks
  logic [15:0] irq_entries;                                     // cpu model count
  ahb_req_t    req;                                             // request
  ahb_rsp_t    rsp;                                             // answer
  int          fail_count = 0, num_checks = 0, cycles = 0;      // counters
  int          prio [40];                                       // model levels
  assign req = '{hsel, haddr, htrans, hwrite, 3'h2, rsp.hreadyout};
  always #2.5 hclk = ~hclk;
  level_pending_regs dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hwdata(hwdata), .ahb_rsp(rsp),
    .src_req(src_req), .level_mask(level_mask), .level_pending_bits(lp), .normal_pending_bits(np), .normal_irq(irq));
  cpu_irq_sink cpu (.hclk(hclk), .hresetn(hresetn), .normal_irq(irq), .irq_entries(irq_entries));
  // one single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, well above the roughly 580 cycles needed
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    void'($urandom(71));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, with the unmapped holes between
    for (int a = 'h0c; a <= 'h20; a += 4)
    begin
      xfer(0, 32'h00c50000 + 32'(a), '0);
      chk("reset value", '0, rd);
    end
    $display("reset test done");
    for (int t = 0; t < 6; t++)
    begin
      // first pass puts sources on the edge levels 0 and 31
      foreach (prio[s])
      begin
        prio[s] = (t == 0) ? (s % 2) * 31 : $urandom_range(31);
        xfer(1, `PRIORITY_SELECT_BASE_OFS + 32'(4 * s), 32'(prio[s]));
      end
      src_req <= 40'({$urandom(), $urandom()});
      level_mask <= $urandom();
      en = (t == 5) ? '0 : $urandom();
      xfer(1, `NORMAL_LEVEL_ENABLES_OFS, en);
      xfer(1, `LEVEL_PENDING_FLAGS_OFS, '1);
      xfer(1, `NORMAL_PENDING_FLAGS_OFS, '1);
      lvl = '0;
      foreach (prio[s])
        if (src_req[s])
          lvl[prio[s]] = 1'b1;
      xfer(0, `NORMAL_LEVEL_ENABLES_OFS, '0);
      chk("enables", en, rd);
      xfer(0, `LEVEL_PENDING_FLAGS_OFS, '0);
      chk("level pending", lvl, rd);
      xfer(0, `NORMAL_PENDING_FLAGS_OFS, '0);
      chk("normal pending", lvl & en, rd);
      chk("normal irq", {31'h0, |(lvl & en & ~level_mask)}, {31'h0, irq});
      chk("level pins", lvl, lp);
      chk("normal pins", lvl & en, np);
      $display("random test %0d done", t);
    end
    // requests drop: nothing may stay latched
    src_req <= '0;
    repeat (3) @(posedge hclk);
    xfer(0, `LEVEL_PENDING_FLAGS_OFS, '0);
    chk("level after drop", '0, rd);
    chk("cpu entries", 32'h1, {31'h0, irq_entries != '0});
    $display("drop test done");
    test_done();
  end
endmodule
